// ===== rea_pkg.sv
// constants and types for the reactive energy and apparent power datapath
package rea_pkg;

  // computation tick timing
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned COMP_PERIOD_NS = 125000;
  localparam int unsigned TICK_CYCLES    = COMP_PERIOD_NS / CLK_PERIOD_NS;

  // scaling constants
  localparam logic [25:0]        FULL_SCALE_POWER = 26'h1FF6A6B;
  localparam logic [23:0]        FULL_SCALE_RMS   = 24'h3FF6A6;
  localparam logic [47:0]        RMS_FS_SQ        = {24'h000000, FULL_SCALE_RMS}
                                                  * {24'h000000, FULL_SCALE_RMS};
  localparam logic signed [27:0] GAIN_ONE         = 28'sh0800000;
  localparam int unsigned        GAIN_FRAC        = 23;
  localparam int unsigned        VA_SHIFT         = 4;
  localparam int unsigned        PROD_SHIFT       = 46;

  // register indices on the register port
  localparam logic [4:0] ADDR_ENERGY_BASE = 5'h00;
  localparam logic [4:0] ADDR_VA_BASE     = 5'h06;
  localparam logic [4:0] ADDR_GAIN_BASE   = 5'h09;
  localparam logic [4:0] ADDR_NOMINAL_VOLTAGE        = 5'h0C;
  localparam logic [4:0] ADDR_ACCUMULATION_MODE_REG     = 5'h0D;
  localparam logic [4:0] ADDR_LINE_CYCLE_MODE_REG    = 5'h0E;
  localparam logic [4:0] ADDR_HALFCYC     = 5'h0F;
  localparam logic [4:0] ADDR_COMPENSATION_MODE_REG    = 5'h10;
  localparam logic [4:0] ADDR_THR_LO      = 5'h11;
  localparam logic [4:0] ADDR_THR_HI      = 5'h12;
  localparam logic [4:0] ADDR_STATUS      = 5'h13;
  localparam logic [4:0] ADDR_MASK        = 5'h14;

  // field positions
  localparam int unsigned WIRING_LSB   = 4;
  localparam int unsigned FREQSEL_LSB  = 2;
  localparam int unsigned LCYC_VAR_BIT = 1;
  localparam int unsigned ZX_LSB       = 3;
  localparam int unsigned CLR_READ_BIT = 6;
  localparam int unsigned NOM_EN_LSB   = 11;
  localparam int unsigned DONE_BIT     = 5;

  // reset values, and the sign-adjusted frequency output select code
  localparam logic [7:0]  ACCUMULATION_MODE_REG_RST  = 8'h00;
  localparam logic [7:0]  LINE_CYCLE_MODE_REG_RST = 8'h38;
  localparam logic [15:0] HALFCYC_RST  = 16'hFFFF;
  localparam logic [15:0] COMPENSATION_MODE_REG_RST = 16'h0000;
  localparam logic [47:0] THR_RST      = 48'h000001FF6A6B;
  localparam logic [1:0]  FREQ_SIGN_ADJ = 2'b10;

  typedef enum logic [1:0] {
    REA_WIRE_OWN   = 2'b00,
    REA_WIRE_B0    = 2'b01,
    REA_WIRE_VB_AC = 2'b10,
    REA_WIRE_VB_A  = 2'b11
  } rea_wiring_t;

endpackage : rea_pkg

// ===== rea_datapath.sv
// reactive energy accumulation and apparent power datapath, one module
//
// Overview of operation
// - accumulate reactive energy once per 125 us tick
// - full-scale quadrature power equals one threshold per tick
// - var-hour registers are 32 bits signed
// - wiring mode 00 own products, 01 zeroes B
// - mode 10 uses VB=-VA-VC, 11 uses VB=-VA
// - registers signed; frequency output signed or sign-adjusted
// - line-cycle mode transfers after programmed half cycles
// - line-cycle mode enabled by bit 1
// - three bits pick which phase crossings count
// - apparent power is rms voltage times rms current
// - apparent power scaled by full-scale constant over 16
// - apparent power held as readable 24-bit values
// - signed 24-bit gain scales by one plus gain/2^23
// - C00000 halves, 400000 adds fifty percent
// - gain reads zero top nibble, sign extended to 28
// - no offset correction in apparent path
// - per-phase bits select nominal-voltage apparent power
// - nominal voltage reads with upper eight bits zero
// - var-hour registers wrap and keep accumulating
// - first stage accumulates, pulses, subtracts threshold
// - clear-on-read when enabled outside line-cycle mode
`timescale 1ns/1ps
`default_nettype none

module rea_datapath
  import rea_pkg::*;
#(
  parameter int unsigned TICK_COUNT = rea_pkg::TICK_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic [4:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [31:0]             reg_wdata,
  output var  logic [31:0]             reg_rdata,
  input  wire logic [2:0][23:0]        volt_inst,
  input  wire logic [2:0][23:0]        curr_shift,
  input  wire logic [2:0][23:0]        curr_fund_shift,
  input  wire logic [2:0][23:0]        volt_rms,
  input  wire logic [2:0][23:0]        curr_rms,
  input  wire logic [2:0]              zero_cross,
  output var  logic                    comp_tick,
  output var  logic                    reactive_cf_pulse,
  output var  logic                    reactive_cf_neg,
  output var  logic                    fund_cf_pulse,
  output var  logic                    fund_cf_neg,
  output var  logic                    line_cycle_done,
  output var  logic                    interrupt_line_n
);
  import rea_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic signed [63:0] scale_power(
    input logic signed [24:0] v,
    input logic signed [23:0] i
  );
    logic signed [48:0] prod;
    logic signed [75:0] wide;
    prod = v * i;
    wide = prod * $signed({1'b0, FULL_SCALE_POWER});
    return 64'(wide >>> PROD_SHIFT);
  endfunction : scale_power

  function automatic logic [23:0] apparent(
    input logic signed [24:0] v,
    input logic [23:0]        i,
    input logic [23:0]        g
  );
    logic signed [79:0] s;
    logic signed [27:0] gx;
    gx = {{4{g[23]}}, g};
    s  = v * $signed({1'b0, i});
    s  = s * $signed({1'b0, FULL_SCALE_POWER});
    s  = s / $signed({1'b0, RMS_FS_SQ});
    s  = s >>> VA_SHIFT;
    s  = (s * (GAIN_ONE + gx)) >>> GAIN_FRAC;
    return s[23:0];
  endfunction : apparent

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0]        acc_mode_q;
  logic [7:0]        lcyc_mode_q;
  logic [15:0]       half_cyc_q;
  logic [15:0]       comp_mode_q;
  logic [47:0]       thr_q;
  logic [2:0][23:0]  gain_q;
  logic [23:0]       nominal_voltage_q;
  logic [31:0]       mask_q;
  logic              done_q;
  rea_wiring_t       wiring;
  logic              line_cycle_reactive_enable_en;
  logic              clr_read_en;
  logic              wr_any;

  assign wiring      = rea_wiring_t'(acc_mode_q[WIRING_LSB +: 2]);
  assign line_cycle_reactive_enable_en     = lcyc_mode_q[LCYC_VAR_BIT];
  assign clr_read_en = lcyc_mode_q[CLR_READ_BIT];
  assign wr_any      = reg_wr;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_mode_q  <= ACCUMULATION_MODE_REG_RST;
      lcyc_mode_q <= LINE_CYCLE_MODE_REG_RST;
      half_cyc_q  <= HALFCYC_RST;
      comp_mode_q <= COMPENSATION_MODE_REG_RST;
      thr_q       <= THR_RST;
      gain_q      <= '0;
      nominal_voltage_q      <= '0;
      mask_q      <= '0;
    end else if (wr_any) begin
      unique case (reg_addr)
        ADDR_ACCUMULATION_MODE_REG:  acc_mode_q  <= reg_wdata[7:0];
        ADDR_LINE_CYCLE_MODE_REG: lcyc_mode_q <= reg_wdata[7:0];
        ADDR_HALFCYC:  half_cyc_q  <= reg_wdata[15:0];
        ADDR_COMPENSATION_MODE_REG: comp_mode_q <= reg_wdata[15:0];
        ADDR_THR_LO:   thr_q[23:0] <= reg_wdata[23:0];
        ADDR_THR_HI:   thr_q[47:24] <= reg_wdata[23:0];
        ADDR_NOMINAL_VOLTAGE:     nominal_voltage_q      <= reg_wdata[23:0];
        ADDR_MASK:     mask_q      <= reg_wdata;
        ADDR_GAIN_BASE:              gain_q[0] <= reg_wdata[23:0];
        ADDR_GAIN_BASE + 5'h01:      gain_q[1] <= reg_wdata[23:0];
        ADDR_GAIN_BASE + 5'h02:      gain_q[2] <= reg_wdata[23:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // computation tick

  logic [13:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q == 14'(TICK_COUNT - 1));

  always_ff @(posedge core_clk) begin
    if (reset || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 14'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      comp_tick <= 1'b0;
    end else begin
      comp_tick <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instantaneous reactive power with wiring selection

  logic signed [24:0] vsel [3];
  logic signed [63:0] pw   [6];

  always_comb begin
    vsel[0] = 25'(signed'(volt_inst[0]));
    vsel[2] = 25'(signed'(volt_inst[2]));
    unique case (wiring)
      REA_WIRE_VB_AC: vsel[1] = -vsel[0] - vsel[2];
      REA_WIRE_VB_A:  vsel[1] = -vsel[0];
      default:        vsel[1] = 25'(signed'(volt_inst[1]));
    endcase
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pw[p]     = scale_power(vsel[p], signed'(curr_shift[p]));
      pw[p + 3] = scale_power(vsel[p], signed'(curr_fund_shift[p]));
    end
    if (wiring == REA_WIRE_B0) begin
      pw[1] = '0;
      pw[4] = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first stage: threshold accumulators, indices 0-2 total, 3-5 fundamental

  logic signed [47:0] acc_q [6];
  logic [5:0]         pulse_pos_q;
  logic [5:0]         pulse_neg_q;
  logic signed [63:0] thr_s;

  assign thr_s = $signed({16'h0000, thr_q});

  // threshold at full scale gives one pulse per tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int k = 0; k < 6; k++) begin
        acc_q[k] <= '0;
      end
      pulse_pos_q <= '0;
      pulse_neg_q <= '0;
    end else begin
      pulse_pos_q <= '0;
      pulse_neg_q <= '0;
      if (tick) begin
        for (int k = 0; k < 6; k++) begin
          if (64'(acc_q[k]) + pw[k] >= thr_s) begin
            acc_q[k]       <= 48'(64'(acc_q[k]) + pw[k] - thr_s);
            pulse_pos_q[k] <= 1'b1;
          end else if (64'(acc_q[k]) + pw[k] <= -thr_s) begin
            acc_q[k]       <= 48'(64'(acc_q[k]) + pw[k] + thr_s);
            pulse_neg_q[k] <= 1'b1;
          end else begin
            acc_q[k] <= 48'(64'(acc_q[k]) + pw[k]);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half line cycle counting

  logic [15:0] half_cnt_q;
  logic [1:0]  zx_hits;
  logic [2:0]  zx_used;
  logic        transfer;

  assign zx_used  = zero_cross & lcyc_mode_q[ZX_LSB +: 3];
  assign zx_hits  = 2'(zx_used[0]) + 2'(zx_used[1]) + 2'(zx_used[2]);
  assign transfer = line_cycle_reactive_enable_en && (zx_hits != 2'b00)
                 && (half_cnt_q + 16'(zx_hits) >= half_cyc_q);

  always_ff @(posedge core_clk) begin
    if (reset || !line_cycle_reactive_enable_en || transfer) begin
      half_cnt_q <= '0;
    end else begin
      half_cnt_q <= half_cnt_q + 16'(zx_hits);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second stage: var-hour registers

  logic [31:0] int_q    [6];
  logic [31:0] energy_q [6];
  logic [31:0] delta    [6];

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      delta[k] = pulse_pos_q[k] ? 32'h00000001 :
                 pulse_neg_q[k] ? 32'hFFFFFFFF : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int k = 0; k < 6; k++) begin
        int_q[k]    <= '0;
        energy_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (line_cycle_reactive_enable_en) begin
          if (transfer) begin
            energy_q[k] <= int_q[k] + delta[k];
            int_q[k]    <= '0;
          end else begin
            int_q[k] <= int_q[k] + delta[k];
          end
        end else if (reg_rd && clr_read_en
                     && reg_addr == ADDR_ENERGY_BASE + 5'(k)) begin
          energy_q[k] <= delta[k];
        end else begin
          energy_q[k] <= energy_q[k] + delta[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency output pulses, signed net or sign-adjusted count

  logic signed [2:0] net_tot;
  logic signed [2:0] net_fund;
  logic              sign_adj;

  assign sign_adj = acc_mode_q[FREQSEL_LSB +: 2] == FREQ_SIGN_ADJ;

  always_comb begin
    net_tot  = '0;
    net_fund = '0;
    for (int p = 0; p < 3; p++) begin
      if (pulse_pos_q[p] || (sign_adj && pulse_neg_q[p])) begin
        net_tot = net_tot + 3'sd1;
      end else if (pulse_neg_q[p]) begin
        net_tot = net_tot - 3'sd1;
      end
      if (pulse_pos_q[p + 3] || (sign_adj && pulse_neg_q[p + 3])) begin
        net_fund = net_fund + 3'sd1;
      end else if (pulse_neg_q[p + 3]) begin
        net_fund = net_fund - 3'sd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reactive_cf_pulse <= 1'b0;
      reactive_cf_neg   <= 1'b0;
      fund_cf_pulse     <= 1'b0;
      fund_cf_neg       <= 1'b0;
    end else begin
      reactive_cf_pulse <= net_tot != 3'sd0;
      reactive_cf_neg   <= net_tot < 3'sd0;
      fund_cf_pulse     <= net_fund != 3'sd0;
      fund_cf_neg       <= net_fund < 3'sd0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apparent power; offsets come only from the rms blocks upstream

  logic [23:0]        va_q [3];
  logic signed [24:0] va_volt [3];

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      va_volt[p] = comp_mode_q[NOM_EN_LSB + p]
                 ? 25'(signed'(nominal_voltage_q))
                 : $signed({1'b0, volt_rms[p]});
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int p = 0; p < 3; p++) begin
        va_q[p] <= '0;
      end
    end else if (tick) begin
      for (int p = 0; p < 3; p++) begin
        va_q[p] <= apparent(va_volt[p], curr_rms[p], gain_q[p]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, interrupt and read port

  // done flag, set wins over clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (transfer) begin
      done_q <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_STATUS
                 && reg_wdata[DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interrupt_line_n <= 1'b1;
      line_cycle_done  <= 1'b0;
    end else begin
      interrupt_line_n <= !(done_q && mask_q[DONE_BIT]);
      line_cycle_done  <= transfer;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      for (int k = 0; k < 6; k++) begin
        if (reg_addr == ADDR_ENERGY_BASE + 5'(k)) reg_rdata <= energy_q[k];
      end
      for (int p = 0; p < 3; p++) begin
        if (reg_addr == ADDR_VA_BASE + 5'(p)) begin
          reg_rdata <= {8'h00, va_q[p]};
        end
        if (reg_addr == ADDR_GAIN_BASE + 5'(p)) begin
          reg_rdata <= {4'h0, {4{gain_q[p][23]}}, gain_q[p]};
        end
      end
      unique case (reg_addr)
        ADDR_NOMINAL_VOLTAGE:     reg_rdata <= {8'h00, nominal_voltage_q};
        ADDR_ACCUMULATION_MODE_REG:  reg_rdata <= {24'h000000, acc_mode_q};
        ADDR_LINE_CYCLE_MODE_REG: reg_rdata <= {24'h000000, lcyc_mode_q};
        ADDR_HALFCYC:  reg_rdata <= {16'h0000, half_cyc_q};
        ADDR_COMPENSATION_MODE_REG: reg_rdata <= {16'h0000, comp_mode_q};
        ADDR_THR_LO:   reg_rdata <= {8'h00, thr_q[23:0]};
        ADDR_THR_HI:   reg_rdata <= {8'h00, thr_q[47:24]};
        ADDR_STATUS:   reg_rdata <= 32'(done_q) << DONE_BIT;
        ADDR_MASK:     reg_rdata <= mask_q;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_transfer;
    transfer ##1 line_cycle_done;
  endsequence

  property p_tick_single;
    comp_tick |=> !comp_tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("tick lasted more than one cycle");

  property p_pulse_after_tick;
    (pulse_pos_q != 6'h00 || pulse_neg_q != 6'h00) |-> comp_tick;
  endproperty
  a_pulse_after_tick: assert property (p_pulse_after_tick)
    else $error("energy pulse without a tick");

  property p_wrap;
    (pulse_pos_q[0] && !line_cycle_reactive_enable_en && !reg_rd)
      |=> energy_q[0] == $past(energy_q[0]) + 32'h00000001;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("var-hour register did not step by one");

  property p_b_zero;
    wiring == REA_WIRE_B0 |-> pw[1] == 64'sd0 && pw[4] == 64'sd0;
  endproperty
  a_b_zero: assert property (p_b_zero)
    else $error("phase b power not zero in mode 01");

  property p_clear_read;
    (reg_rd && clr_read_en && !line_cycle_reactive_enable_en && reg_addr == ADDR_ENERGY_BASE
     && !pulse_pos_q[0] && !pulse_neg_q[0]) |=> energy_q[0] == 32'h0;
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("read did not clear var-hour register");

  property p_transfer;
    s_transfer |-> half_cnt_q == 16'h0000 && done_q;
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("line-cycle transfer did not restart");

  property p_gain_read;
    (reg_rd && reg_addr == ADDR_GAIN_BASE) |=>
      reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{gain_q[0][23]}};
  endproperty
  a_gain_read: assert property (p_gain_read)
    else $error("gain read format wrong");

  property p_irq;
    (done_q && mask_q[DONE_BIT]) |=> !interrupt_line_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line not asserted");

endmodule : rea_datapath

`default_nettype wire

// ===== rea_host.sv
// host model that drives the register port of the datapath
`timescale 1ns/1ps
`default_nettype none

module rea_host
  import rea_pkg::*;
(
  input  wire logic        core_clk,
  output var  logic [4:0]  reg_addr,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h00000000;
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    // stale data would hide a late capture, so show its inverse
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd

  task automatic lcyc(input logic [2:0] zx, input logic [15:0] n);
    wr(ADDR_HALFCYC, {16'h0000, n});
    wr(ADDR_LINE_CYCLE_MODE_REG, {24'h000000, 2'b00, zx, 3'b010});
  endtask : lcyc
endmodule : rea_host

`default_nettype wire

// ===== rea_datapath_bench.sv
// self-checking bench for the reactive energy and apparent power datapath
`timescale 1ns/1ps
`default_nettype none

module rea_datapath_bench;
  import rea_pkg::*;
  // short tick keeps the run brief; expectations count ticks
  localparam int unsigned TK = 16;
  logic             core_clk;
  logic             reset;
  logic [4:0]       reg_addr;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_wdata;
  logic [31:0]      reg_rdata;
  logic [2:0][23:0] volt_inst;
  logic [2:0][23:0] curr_shift;
  logic [2:0][23:0] curr_fund_shift;
  logic [2:0][23:0] volt_rms;
  logic [2:0][23:0] curr_rms;
  logic [2:0]       zero_cross;
  logic             comp_tick;
  logic             reactive_cf_pulse;
  logic             reactive_cf_neg;
  logic             fund_cf_pulse;
  logic             fund_cf_neg;
  logic             line_cycle_done;
  logic             interrupt_line_n;
  int               n_mismatch;
  int               checks_done;
  int               np;
  int               nn;
  int               nf;

  assign curr_fund_shift = curr_shift;

  rea_datapath #(.TICK_COUNT(TK)) i_rea_datapath (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .volt_inst(volt_inst),
    .curr_shift(curr_shift), .curr_fund_shift(curr_fund_shift),
    .volt_rms(volt_rms), .curr_rms(curr_rms), .zero_cross(zero_cross),
    .comp_tick(comp_tick), .reactive_cf_pulse(reactive_cf_pulse),
    .reactive_cf_neg(reactive_cf_neg), .fund_cf_pulse(fund_cf_pulse),
    .fund_cf_neg(fund_cf_neg), .line_cycle_done(line_cycle_done),
    .interrupt_line_n(interrupt_line_n)
  );

  rea_host i_rea_host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (reactive_cf_pulse === 1'b1) np++;
    if (reactive_cf_pulse === 1'b1 && reactive_cf_neg === 1'b1) nn++;
    if (fund_cf_pulse === 1'b1 && fund_cf_neg === 1'b1) nf++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_rea_host.rd(a, d);
    check($sformatf("register %h", a), d, e);
  endtask : rdchk

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      while (comp_tick !== 1'b1) @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
  endtask : ticks

  task automatic pulse_zx(input logic [2:0] z);
    @(posedge core_clk);
    #1 zero_cross = z;
    @(posedge core_clk);
    #1 zero_cross = 3'b000;
  endtask : pulse_zx

  task automatic done_in(input logic e);
    int k;
    k = 0;
    repeat (4) begin
      @(posedge core_clk);
      if (line_cycle_done === 1'b1) k++;
    end
    check("done pulse", {31'h0, k != 0}, {31'h0, e});
    check("irq", {31'h0, interrupt_line_n}, {31'h0, ~e});
  endtask : done_in

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk(ADDR_LINE_CYCLE_MODE_REG, 32'h00000038);
    rdchk(ADDR_THR_LO, 32'h00FF6A6B);
    rdchk(ADDR_THR_HI, 32'h00000001);
    rdchk(ADDR_GAIN_BASE, 32'h00000000);
    rdchk(5'h1F, 32'h00000000);
    i_rea_host.wr(ADDR_GAIN_BASE + 5'h01, 32'h00C00000);
    rdchk(ADDR_GAIN_BASE + 5'h01, 32'h0FC00000);
    i_rea_host.wr(ADDR_NOMINAL_VOLTAGE, 32'h00876543);
    rdchk(ADDR_NOMINAL_VOLTAGE, 32'h00876543);
    i_rea_host.wr(ADDR_ENERGY_BASE, 32'h12345678);
    rdchk(ADDR_ENERGY_BASE, 32'h00000000);
  endtask : t_regs

  task automatic t_va;
    volt_rms    = {3{24'h3FF6A6}};
    curr_rms    = {3{24'h3FF6A6}};
    volt_rms[0] = 24'h000000;
    i_rea_host.wr(ADDR_GAIN_BASE + 5'h02, 32'h00400000);
    ticks(2);
    rdchk(ADDR_VA_BASE, 32'h00000000);
    rdchk(ADDR_VA_BASE + 5'h01, 32'h000FFB53);
    rdchk(ADDR_VA_BASE + 5'h02, 32'h002FF1F9);
    i_rea_host.wr(ADDR_NOMINAL_VOLTAGE, {8'h00, FULL_SCALE_RMS});
    i_rea_host.wr(ADDR_GAIN_BASE, 32'h00400000);
    i_rea_host.wr(ADDR_COMPENSATION_MODE_REG, 32'h1 << NOM_EN_LSB);
    ticks(2);
    rdchk(ADDR_VA_BASE, 32'h002FF1F9);
  endtask : t_va

  task automatic t_wire;
    logic [31:0] r0[4];
    logic [31:0] r1[4];
    logic [4:0]  ea[4];
    int          eb[4];
    int          ex[4];
    ea = '{5'h00, 5'h01, 5'h02, 5'h04};
    eb = '{1, 0, 0, -1};
    i_rea_host.wr(ADDR_THR_LO, 32'h007FDA9A);
    i_rea_host.wr(ADDR_THR_HI, 32'h00000000);
    volt_inst  = {24'hC00000, 24'h400000, 24'h400000};
    curr_shift = {24'h000000, 24'h400000, 24'h400000};
    for (int m = 0; m < 4; m++) begin
      i_rea_host.wr(ADDR_ACCUMULATION_MODE_REG, 32'(m) << WIRING_LSB);
      ticks(1);
      foreach (ea[k]) i_rea_host.rd(ea[k], r0[k]);
      ticks(4);
      foreach (ea[k]) i_rea_host.rd(ea[k], r1[k]);
      ex = '{4, 4 * eb[m], 0, 4 * eb[m]};
      foreach (ea[k]) check("delta", r1[k] - r0[k], 32'(ex[k]));
    end
  endtask : t_wire

  task automatic t_cf;
    curr_shift[0] = 24'hC00000;
    for (int f = 0; f < 2; f++) begin
      i_rea_host.wr(ADDR_ACCUMULATION_MODE_REG,
                    {26'h0, 2'b01, (f != 0) ? FREQ_SIGN_ADJ : 2'b00, 2'b00});
      ticks(1);
      #1;
      np = 0;
      nn = 0;
      nf = 0;
      ticks(4);
      check("cf sign", {30'h0, np != 0, nn == ((f != 0) ? 0 : np)}, 32'h3);
      check("fund cf sign", nf, nn);
    end
  endtask : t_cf

  task automatic t_line;
    logic [31:0] b0;
    logic [31:0] b1;
    i_rea_host.wr(ADDR_ACCUMULATION_MODE_REG, 32'h00000000);
    curr_shift[0] = 24'h400000;
    i_rea_host.wr(ADDR_MASK, 32'h00000020);
    i_rea_host.lcyc(3'b001, 16'h0002);
    ticks(1);
    i_rea_host.rd(ADDR_ENERGY_BASE, b0);
    ticks(3);
    i_rea_host.rd(ADDR_ENERGY_BASE, b1);
    check("held", b1, b0);
    pulse_zx(3'b010);
    pulse_zx(3'b001);
    done_in(1'b0);
    pulse_zx(3'b001);
    done_in(1'b1);
    i_rea_host.rd(ADDR_ENERGY_BASE, b1);
    check("moved", {31'h0, b1 != b0}, 32'h1);
    i_rea_host.rd(ADDR_STATUS, b1);
    check("done flag", b1 & 32'h20, 32'h20);
    i_rea_host.wr(ADDR_STATUS, 32'h00000020);
    repeat (3) @(posedge core_clk);
    check("irq off", {31'h0, interrupt_line_n}, 32'h1);
    i_rea_host.lcyc(3'b111, 16'h0003);
    pulse_zx(3'b111);
    done_in(1'b1);
    i_rea_host.wr(ADDR_LINE_CYCLE_MODE_REG, 32'h00000040);
    ticks(1);
    i_rea_host.rd(ADDR_ENERGY_BASE, b1);
    i_rea_host.rd(ADDR_ENERGY_BASE, b1);
    check("read clears", b1, 32'h00000000);
  endtask : t_line

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    zero_cross = 3'b000;
    volt_inst = '0;
    curr_shift = '0;
    volt_rms = '0;
    curr_rms = '0;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    t_regs;
    t_va;
    t_wire;
    t_cf;
    t_line;
    wrap_up;
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
endmodule : rea_datapath_bench

`default_nettype wire
